// ==== bench/sfs_conv_model.sv ====
// Converter link model that sends one result per clocked frame
`timescale 1ns/1ps
`default_nettype none
module sfs_conv_model (
  // Link
  output logic        convClk,
  output logic        convValid,
  output logic [2:0]  convChan,
  output logic [15:0] convResult
);
  initial begin
    convClk = 1'b0;
    convValid = 1'b0;
    convChan = 3'h0;
    convResult = 16'h0000;
  end
  // Clock stands still between frames; released data shows its inverse
  task automatic send(input logic [2:0] c, input logic [15:0] r);
    convValid = 1'b1;
    convChan = c;
    convResult = r;
    #80 convClk = 1'b1;
    #80 convClk = 1'b0;
    convValid = 1'b0;
    convResult = ~r;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the flag unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic convClk, convValid;
  logic [2:0] convChan;
  logic [15:0] convResult;
  logic [3:0] seen, expq[$];
  int err_total = 0, samples_checked = 0, seed = 32;
  event got;
  always #5 mclk = ~mclk;
  sfs_conv_model sfs_conv_model_i (.convClk(convClk), .convValid(convValid),
    .convChan(convChan), .convResult(convResult));
  sfs_flag_unit sfs_flag_unit_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .convClk(convClk),
    .convValid(convValid), .convChan(convChan), .convResult(convResult), .irq(irq));
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic waitrdy;
    int n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 50) err_total++;
    if (n >= 50) final_report();
  endtask
  // One whole-word transfer; a read notes its expected low four bits
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] e);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitrdy();
    htrans <= sfs_pkg::HTRANS_IDLE;
    hwdata <= d;
    if (!w) expq.push_back(e);
    waitrdy();
    seen = hrdata[3:0];
    if (!w) ->got;
  endtask
  task automatic conv(input logic [2:0] c, input logic [15:0] r);
    sfs_conv_model_i.send(c, r);
    repeat (12) @(posedge mclk);
  endtask
  initial forever begin
    @got;
    chk(seen, expq.pop_front());
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'h1);
    bus(1'b1, sfs_pkg::OFF_LIMIT, 32'h100, 4'h0);
    bus(1'b1, sfs_pkg::OFF_CHAN_EN, 32'h1, 4'h0);
    bus(1'b1, sfs_pkg::OFF_INT_MASK, 32'he, 4'h0);
    bus(1'b1, sfs_pkg::OFF_CONTROL, 32'h201, 4'h0);
    conv(3'h1, 16'($random(seed)) & 16'h0ff0);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'h0);
    conv(3'h0, 16'h0500);
    chk({3'h0, irq}, 4'h1);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'ha);
    conv(3'h0, 16'hfff0);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'he);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'he);
    bus(1'b0, sfs_pkg::OFF_DATA, 32'h0, 4'h0);
    bus(1'b0, sfs_pkg::OFF_DATA, 32'h0, 4'h0);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'h1);
    chk({3'h0, irq}, 4'h0);
    bus(1'b1, sfs_pkg::OFF_CONTROL, 32'h203, 4'h0);
    for (int k = 0; k < 17; k++) conv(3'h1, 16'(k));
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'h6);
    chk({3'h0, irq}, 4'h1);
    bus(1'b0, sfs_pkg::OFF_DATA, 32'h0, 4'h1);
    bus(1'b1, sfs_pkg::OFF_CMD, 32'h1, 4'h0);
    bus(1'b0, sfs_pkg::OFF_STATUS, 32'h0, 4'h1);
    chk({3'h0, irq}, 4'h0);
    repeat (2) @(posedge mclk);
    final_report();
  end
endmodule
`default_nettype wire

// ==== hw/sfs_flag_unit.sv ====
// Sample buffer with threshold, overrun and fill-level flags on AHB-Lite
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A stored result of an enabled channel at or below the lower limit sets status bit 3.
// - The below-limit and overrun flags hold until the buffer becomes empty.
// - In watermark mode a result arriving after the watermark count was reached and before the buffer was emptied is dropped and sets bit 2.
// - In streaming mode a result arriving at a full buffer evicts the oldest and sets overrun.
// - Status bit 1 is set while the stored count is at or above the watermark count.
// - Status bit 1 clears as soon as the stored count falls below the watermark count.
// - Each flag's interrupt rises and falls in the same cycle as the flag, with no acknowledge.
// - Flags read 1 when triggered, and below-limit, overrun and fill-level reset to 0.
// - The buffer counts as emptied while disabled, on enable, on reading its last entry, or on a clear command.
// - The lower limit is a 12-bit field in bits 11 to 0, reset to zero, used for the comparison.
module sfs_flag_unit (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Converter link
  input  wire logic        convClk,
  input  wire logic        convValid,
  input  wire logic [2:0]  convChan,
  input  wire logic [15:0] convResult,
  // Interrupt
  output logic             irq
);
  // Link after synchronisation
  logic [sfs_pkg::SYNC_W-1:0] linkRaw;
  sfs_pkg::sfs_conv_t         linkSync;
  logic                       prevClk;
  logic                       next_prevClk;
  logic                       convEv;

  // Configuration registers
  logic                       enable;
  logic                       next_enable;
  sfs_pkg::sfs_mode_t         mode;
  sfs_pkg::sfs_mode_t         next_mode;
  logic [sfs_pkg::CNT_W-1:0]  wm;
  logic [sfs_pkg::CNT_W-1:0]  next_wm;
  logic [sfs_pkg::THR_W-1:0]  limit;
  logic [sfs_pkg::THR_W-1:0]  next_limit;
  logic [sfs_pkg::NCHAN-1:0]  chanEn;
  logic [sfs_pkg::NCHAN-1:0]  next_chanEn;
  logic [sfs_pkg::FLAG_W-1:0] mask;
  logic [sfs_pkg::FLAG_W-1:0] next_mask;

  // Bus pipeline
  logic                       accept;
  logic                       addrHit;
  logic                       wrPend;
  logic                       next_wrPend;
  logic [7:0]                 wrAddr;
  logic [7:0]                 next_wrAddr;
  logic [31:0]                readWord;
  logic [31:0]                next_hrdata;
  logic                       next_hreadyout;
  logic                       next_hresp;
  logic                       statusRd;
  logic                       rdPop;
  logic                       cmdClear;
  logic                       enRise;

  // Buffer and flags
  logic [sfs_pkg::DATA_W-1:0] headData;
  logic [sfs_pkg::CNT_W-1:0]  count;
  logic [sfs_pkg::CNT_W-1:0]  nextCnt;
  logic                       atDepth;
  logic                       clearAll;
  logic                       push;
  logic                       pop;
  logic                       evict;
  logic                       dropWm;
  logic                       belowHit;
  logic                       emptyEvt;
  logic                       wmFull;
  logic                       next_wmFull;
  sfs_pkg::sfs_flags_t        flags;
  sfs_pkg::sfs_flags_t        next_flags;
  logic [sfs_pkg::FLAG_W-1:0] flagBits;
  logic [sfs_pkg::FLAG_W-1:0] nextFlagBits;
  logic                       next_irq;

  // Top bits only, so the 12-bit limit spans the full result scale
  function automatic logic below_limit(
    input logic [sfs_pkg::DATA_W-1:0] res,
    input logic [sfs_pkg::THR_W-1:0]  lim
  );
    return res[sfs_pkg::DATA_W-1:sfs_pkg::POS_CMP_LSB] <= lim;
  endfunction

  // Occupancy once this cycle's push, pop and clear have acted
  function automatic logic [sfs_pkg::CNT_W-1:0] occupancy_after(
    input logic [sfs_pkg::CNT_W-1:0] cnt,
    input logic                      pu,
    input logic                      po,
    input logic                      clr
  );
    logic [sfs_pkg::CNT_W-1:0] sum;
    sum = cnt + sfs_pkg::CNT_W'(pu) - sfs_pkg::CNT_W'(po);
    return clr ? '0 : sum;
  endfunction

  // Link pins are asynchronous to mclk
  always_comb begin
    linkRaw = {convClk, convValid, convChan, convResult};
  end

  sfs_in_sync #(
    .W (sfs_pkg::SYNC_W)
  ) sfs_in_sync_i (
    .mclk (mclk),
    .rst  (rst),
    .din  (linkRaw),
    .dout (linkSync)
  );

  // Idle link clock is low, so a zero reset value gives no false edge
  always_comb begin
    next_prevClk = linkSync.clk;
    convEv       = linkSync.clk && !prevClk && linkSync.valid && enable;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prevClk <= 1'b0;
    end else begin
      prevClk <= next_prevClk;
    end
  end

  // Zero wait states: read data is captured in the address phase
  always_comb begin
    accept   = hsel && htrans[1] && hready && (hsize == 3'h2);
    addrHit  = (haddr[31:8] == 24'h00_0000);
    statusRd = accept && !hwrite && addrHit && (haddr[7:0] == sfs_pkg::OFF_STATUS);
    rdPop    = accept && !hwrite && addrHit && (haddr[7:0] == sfs_pkg::OFF_DATA)
               && (count != '0);
    cmdClear = wrPend && (wrAddr == sfs_pkg::OFF_CMD) && hwdata[sfs_pkg::BIT_CLEAR];
    enRise   = wrPend && (wrAddr == sfs_pkg::OFF_CONTROL) && hwdata[sfs_pkg::BIT_ENABLE]
               && !enable;
    readWord = sfs_pkg::RST_RDATA;
    case (haddr[7:0])
      sfs_pkg::OFF_STATUS:   readWord = {28'h0, flagBits};
      sfs_pkg::OFF_CONTROL:  readWord = {19'h0, wm, 6'h0, mode, enable};
      sfs_pkg::OFF_LIMIT:    readWord = {20'h0, limit};
      sfs_pkg::OFF_CHAN_EN:  readWord = {24'h0, chanEn};
      sfs_pkg::OFF_DATA: begin
        if (count != '0) begin
          readWord = {16'h0, headData};
        end
      end
      sfs_pkg::OFF_INT_STAT: readWord = {28'h0, flagBits & mask};
      sfs_pkg::OFF_INT_MASK: readWord = {28'h0, mask};
      default: begin
        readWord = sfs_pkg::RST_RDATA;
      end
    endcase
    next_wrPend    = accept && hwrite && addrHit;
    next_wrAddr    = haddr[7:0];
    next_hrdata    = (accept && !hwrite && addrHit) ? readWord : sfs_pkg::RST_RDATA;
    next_hreadyout = 1'b1;
    next_hresp     = sfs_pkg::HRESP_OKAY;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= sfs_pkg::RST_RDATA;
      hreadyout <= 1'b1;
      hresp     <= sfs_pkg::HRESP_OKAY;
    end else begin
      wrPend    <= next_wrPend;
      wrAddr    <= next_wrAddr;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  // Writes land at the end of their data phase
  always_comb begin
    next_enable = enable;
    next_mode   = mode;
    next_wm     = wm;
    next_limit  = limit;
    next_chanEn = chanEn;
    next_mask   = mask;
    if (wrPend) begin
      case (wrAddr)
        sfs_pkg::OFF_CONTROL: begin
          next_enable = hwdata[sfs_pkg::BIT_ENABLE];
          next_mode   = sfs_pkg::sfs_mode_t'(hwdata[sfs_pkg::BIT_MODE]);
          next_wm     = hwdata[sfs_pkg::POS_WM +: sfs_pkg::CNT_W];
        end
        sfs_pkg::OFF_LIMIT:    next_limit  = hwdata[sfs_pkg::THR_W-1:0];
        sfs_pkg::OFF_CHAN_EN:  next_chanEn = hwdata[sfs_pkg::NCHAN-1:0];
        sfs_pkg::OFF_INT_MASK: next_mask   = hwdata[sfs_pkg::FLAG_W-1:0];
        default: begin
          next_mask = mask;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      enable <= 1'b0;
      mode   <= sfs_pkg::SFS_MODE_WATERMARK;
      wm     <= sfs_pkg::RST_WM;
      limit  <= sfs_pkg::RST_LIMIT;
      chanEn <= sfs_pkg::RST_CHAN;
      mask   <= sfs_pkg::RST_MASK;
    end else begin
      enable <= next_enable;
      mode   <= next_mode;
      wm     <= next_wm;
      limit  <= next_limit;
      chanEn <= next_chanEn;
      mask   <= next_mask;
    end
  end

  // Buffer control and flag update; a set beats a clear in one cycle
  always_comb begin
    flagBits = flags;
    atDepth  = (count == sfs_pkg::CNT_W'(sfs_pkg::DEPTH));
    clearAll = cmdClear || enRise || !enable;
    evict    = convEv && (mode == sfs_pkg::SFS_MODE_STREAM) && atDepth && !rdPop
               && !clearAll;
    // Watermark mode stays full from the watermark until emptied
    dropWm   = convEv && (mode == sfs_pkg::SFS_MODE_WATERMARK)
               && (wmFull || (atDepth && !rdPop));
    push     = convEv && !dropWm && !clearAll;
    pop      = rdPop || evict;
    nextCnt  = occupancy_after(count, push, pop, clearAll);
    emptyEvt = (nextCnt == '0) && ((count != '0) || clearAll);
    belowHit = push && chanEn[linkSync.chan]
               && below_limit(linkSync.result, limit);
    next_flags = flags;
    if (emptyEvt) begin
      next_flags.below   = 1'b0;
      next_flags.overrun = 1'b0;
    end
    if (belowHit) begin
      next_flags.below = 1'b1;
    end
    if (dropWm || evict) begin
      next_flags.overrun = 1'b1;
    end
    next_flags.fill  = (nextCnt >= next_wm);
    next_flags.empty = (nextCnt == '0);
    next_wmFull = wmFull;
    if (emptyEvt) begin
      next_wmFull = 1'b0;
    end
    if ((mode == sfs_pkg::SFS_MODE_WATERMARK) && (nextCnt >= wm) && (nextCnt != '0)) begin
      next_wmFull = 1'b1;
    end
    nextFlagBits = next_flags;
    next_irq     = |(nextFlagBits & next_mask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags  <= sfs_pkg::sfs_flags_t'(sfs_pkg::RST_FLAGS);
      wmFull <= 1'b0;
      irq    <= 1'b0;
    end else begin
      flags  <= next_flags;
      wmFull <= next_wmFull;
      irq    <= next_irq;
    end
  end

  sfs_sample_store sfs_sample_store_i (
    .mclk     (mclk),
    .rst      (rst),
    .push     (push),
    .pop      (pop),
    .clear    (clearAll),
    .pushData (linkSync.result),
    .headData (headData),
    .count    (count)
  );

  AST_BELOW_SETS: assert property (@(posedge mclk) disable iff (rst)
    belowHit |=> flags.below)
    else $error("below-limit flag missed a qualifying result");

  AST_STICKY_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    ($fell(flags.below) || $fell(flags.overrun)) |-> $past(emptyEvt))
    else $error("sticky flag cleared without the buffer emptying");

  AST_WM_DROP: assert property (@(posedge mclk) disable iff (rst)
    dropWm |=> flags.overrun && (count <= $past(count)))
    else $error("watermark overrun did not drop the result");

  AST_STREAM_EVICT: assert property (@(posedge mclk) disable iff (rst)
    evict |=> flags.overrun && (count == $past(count)))
    else $error("streaming overrun did not replace the oldest entry");

  AST_FILL_TRACKS: assert property (@(posedge mclk) disable iff (rst)
    flags.fill == (count >= wm))
    else $error("fill-level flag disagrees with the stored count");

  AST_IRQ_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
    irq == |(flagBits & mask))
    else $error("interrupt does not follow the masked flags");

  AST_RESET_FLAGS: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) |-> (flagBits == sfs_pkg::RST_FLAGS) && !irq)
    else $error("flags not at their reset values");

  AST_EMPTY_CLEARS: assert property (@(posedge mclk) disable iff (rst)
    emptyEvt |=> !flags.below && flags.empty)
    else $error("emptying did not clear the flags");

  AST_LIMIT_RESET: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) |-> (limit == sfs_pkg::RST_LIMIT))
    else $error("lower limit not zero after reset");

  AST_STATUS_READ_KEEPS: assert property (@(posedge mclk) disable iff (rst)
    statusRd && !emptyEvt |=> (flags.below || !$past(flags.below))
      && (flags.overrun || !$past(flags.overrun)))
    else $error("status read cleared a flag");
endmodule
`default_nettype wire

// ==== hw/sfs_in_sync.sv ====
// Three-stage synchroniser with agreement filter for outside inputs
`timescale 1ns/1ps
`default_nettype none
module sfs_in_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Asynchronous input and filtered output
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;

  // A bit moves only once stages two and three agree
  always_comb begin
    next_dout = (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// ==== hw/sfs_pkg.sv ====
// Shared constants and types for the sample buffer flag unit
package sfs_pkg;
  // Widths and depths
  localparam int DATA_W  = 16;
  localparam int CHAN_W  = 3;
  localparam int NCHAN   = 8;
  localparam int DEPTH   = 16;
  localparam int PTR_W   = 4;
  localparam int CNT_W   = 5;
  localparam int THR_W   = 12;
  localparam int FLAG_W  = 4;
  localparam int SYNC_W  = 2 + CHAN_W + DATA_W;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_LIMIT    = 8'h08;
  localparam logic [7:0] OFF_CHAN_EN  = 8'h0c;
  localparam logic [7:0] OFF_DATA     = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_CMD      = 8'h1c;

  // Field positions
  localparam int BIT_BELOW    = 3;
  localparam int BIT_OVERRUN  = 2;
  localparam int BIT_FILL     = 1;
  localparam int BIT_EMPTY    = 0;
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_MODE     = 1;
  localparam int POS_WM       = 8;
  localparam int BIT_CLEAR    = 0;
  localparam int POS_CMP_LSB  = DATA_W - THR_W;

  // Values after reset
  localparam logic [FLAG_W-1:0] RST_FLAGS  = 4'h1;
  localparam logic [THR_W-1:0]  RST_LIMIT  = 12'h000;
  localparam logic [CNT_W-1:0]  RST_WM     = 5'h10;
  localparam logic [NCHAN-1:0]  RST_CHAN   = 8'h00;
  localparam logic [FLAG_W-1:0] RST_MASK   = 4'h0;
  localparam logic [31:0]       RST_RDATA  = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic       HRESP_OKAY  = 1'h0;

  typedef enum logic {SFS_MODE_WATERMARK, SFS_MODE_STREAM} sfs_mode_t;

  typedef struct packed {
    logic              below;
    logic              overrun;
    logic              fill;
    logic              empty;
  } sfs_flags_t;

  typedef struct packed {
    logic              clk;
    logic              valid;
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] result;
  } sfs_conv_t;
endpackage

// ==== hw/sfs_sample_store.sv ====
// Circular sample storage with occupancy count
`timescale 1ns/1ps
`default_nettype none
module sfs_sample_store (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      push,
  input  wire logic                      pop,
  input  wire logic                      clear,
  input  wire logic [sfs_pkg::DATA_W-1:0] pushData,
  // State
  output logic      [sfs_pkg::DATA_W-1:0] headData,
  output logic      [sfs_pkg::CNT_W-1:0]  count
);
  logic [sfs_pkg::DATA_W-1:0] mem [sfs_pkg::DEPTH];
  logic [sfs_pkg::PTR_W-1:0]  wrPtr, rdPtr;
  logic [sfs_pkg::PTR_W-1:0]  next_wrPtr, next_rdPtr;
  logic [sfs_pkg::CNT_W-1:0]  next_count;

  // Caller never pushes a full store without popping in the same cycle
  always_comb begin
    next_wrPtr = wrPtr + sfs_pkg::PTR_W'(push);
    next_rdPtr = rdPtr + sfs_pkg::PTR_W'(pop);
    next_count = count + sfs_pkg::CNT_W'(push) - sfs_pkg::CNT_W'(pop);
    if (clear) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (push && !clear) begin
      mem[wrPtr] <= pushData;
    end
  end

  always_comb begin
    headData = mem[rdPtr];
  end
endmodule
`default_nettype wire
